//--- design/dtfm_defs.vh
`ifndef DTFM_DEFS_VH
`define DTFM_DEFS_VH

// register indices on the plain register port (word index)
`define DTFM_ADDR_W 4
`define DTFM_A_GRUN 4'h0
`define DTFM_A_GFFCR 4'h1
`define DTFM_A_GCMP0 4'h2
`define DTFM_A_GCMP1 4'h3
`define DTFM_A_GIM 4'h4
`define DTFM_A_GCR 4'h5
`define DTFM_A_GCNT 4'h6
`define DTFM_A_CRUN 4'h7
`define DTFM_A_CMOD 4'h8
`define DTFM_A_CCNT 4'h9
`define DTFM_A_CAPR 4'ha
`define DTFM_A_CAPF 4'hb
`define DTFM_A_IST 4'hc
`define DTFM_A_PSC 4'hd

// run register bits
`define DTFM_RUN_CNT 0
`define DTFM_RUN_PRE 2

// flip-flop control register fields
`define DTFM_FF_INIT_LO 0
`define DTFM_FF_INIT_HI 1
`define DTFM_FF_TM0 2
`define DTFM_FF_TM1 3
`define DTFM_FF_TC0 4
`define DTFM_FF_TC1 5
`define DTFM_FFCR_RST 6'h03
// preset codes written to the init field; other codes preset nothing and leave the gate to the match toggles
`define DTFM_FF_PRE_HI 2'h1
`define DTFM_FF_PRE_LO 2'h2

// counting mode register fields
`define DTFM_MOD_CLK_LO 0
`define DTFM_MOD_CLK_HI 2
`define DTFM_MOD_CLR 3
`define DTFM_MOD_CPM_LO 4
`define DTFM_MOD_CPM_HI 5
`define DTFM_CLK_EXT 3'h0
`define DTFM_CPM_GATE 2'h3
`define DTFM_MOD_RST 6'h01

// interrupt status / mask bits
`define DTFM_IRQ_M0 0
`define DTFM_IRQ_M1 1
`define DTFM_IRQ_OVF 2
`define DTFM_IRQ_CAPR 3
`define DTFM_IRQ_CAPF 4
`define DTFM_IRQ_W 5
`define DTFM_IM_RST 5'h1f

`define DTFM_PSC_RST 8'h00

`endif

//--- design/dtfm_prescaler.v
`timescale 1ns/10ps
`default_nettype none

// divides mclk to a one-cycle tick every (div+1) cycles while running
module dtfm_prescaler (
  input wire mclk,
  input wire rst,
  input wire run,
  input wire [7:0] div,
  output reg tick
);

  reg [7:0] cnt_r;

  // stopping clears the divider so the next start is phase-aligned
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_r >= div) begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- design/dtfm_top.v
// Functional notes
// - counting clock-select 000 makes the counter free-run on external pin edges.
// - match enables 11 invert the gate output on compare zero and compare one.
// - capture mode 11 latches count on gate rise and gate fall.
// - compare zero match raises the gate; the rise captures into the rise register.
// - compare one match lowers the gate; the fall captures into the fall register.
// - the flip-flop control register presets the gate output level.
// - with capture toggle enables clear, captures leave the gate output alone.
// - the counting mode register can select the external pin as counter clock.
// - the mask can pass only the compare one match to the interrupt.
// - both run bits start prescaler and counter; clearing either stops them.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "dtfm_defs.vh"

module dtfm_top (
  input wire mclk,
  input wire rst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire external_count_pin,
  output reg gate_toggle_output,
  output reg gate_match_interrupt
);

  // software state
  reg [2:0] g_run_r;
  reg [5:0] g_ffcr_r;
  reg [15:0] compare_reg_zero_r;
  reg [15:0] compare_reg_one_r;
  reg [15:0] g_cmp0_buf_r;
  reg [15:0] g_cmp1_buf_r;
  reg g_dbuf_r;
  reg [4:0] interrupt_mask_reg_r;
  reg [2:0] c_run_r;
  reg [5:0] counting_mode_reg_r;
  reg [7:0] psc_div_r;
  reg [4:0] irq_stat_r;
  // hardware state
  reg [15:0] g_cnt_r;
  reg [15:0] c_cnt_r;
  reg [15:0] capture_rise_reg_r;
  reg [15:0] capture_fall_reg_r;
  reg pin_s1_r;
  reg pin_s2_r;
  reg pin_s3_r;
  reg gate_d_r;

  wire g_tick;
  wire c_tick;
  wire g_running;
  wire c_running;
  wire wr_gffcr;
  wire [1:0] ff_pre;
  wire [2:0] counter_clock_select;
  wire [1:0] capture_mode_select;
  wire pin_rise;
  wire c_adv;
  wire g_m0;
  wire g_m1;
  wire g_ovf;
  wire gate_rise;
  wire gate_fall;
  wire cap_r_ev;
  wire cap_f_ev;
  wire toggle_on_match_zero;
  wire toggle_on_match_one;
  wire [4:0] irq_ev;
  wire rd_ist;
  reg ff_nxt;
  reg [15:0] rdata_nxt;

  // a channel runs only with both the prescaler and counter bits set
  assign g_running = g_run_r[`DTFM_RUN_CNT] & g_run_r[`DTFM_RUN_PRE];
  assign c_running = c_run_r[`DTFM_RUN_CNT] & c_run_r[`DTFM_RUN_PRE];

  dtfm_prescaler u_gpsc (
    .mclk(mclk),
    .rst(rst),
    .run(g_running),
    .div(psc_div_r),
    .tick(g_tick)
  );

  dtfm_prescaler u_cpsc (
    .mclk(mclk),
    .rst(rst),
    .run(c_running),
    .div(psc_div_r),
    .tick(c_tick)
  );

  // two-stage synchroniser on the count pin, third stage for edge detection
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= external_count_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_rise = pin_s2_r & ~pin_s3_r;
  assign counter_clock_select = counting_mode_reg_r[`DTFM_MOD_CLK_HI:`DTFM_MOD_CLK_LO];
  assign capture_mode_select = counting_mode_reg_r[`DTFM_MOD_CPM_HI:`DTFM_MOD_CPM_LO];
  // pin edges replace the prescaler tick when the external source is chosen
  assign c_adv = c_running &
                 ((counter_clock_select == `DTFM_CLK_EXT) ? pin_rise : c_tick);

  // gate channel compare matches, qualified by an advancing count
  assign g_m0 = g_running & g_tick & (g_cnt_r == compare_reg_zero_r);
  assign g_m1 = g_running & g_tick & (g_cnt_r == compare_reg_one_r);
  assign g_ovf = g_running & g_tick & (g_cnt_r == 16'hffff);
  assign toggle_on_match_zero = g_ffcr_r[`DTFM_FF_TM0];
  assign toggle_on_match_one = g_ffcr_r[`DTFM_FF_TM1];
  assign wr_gffcr = wr & (addr == `DTFM_A_GFFCR);
  assign ff_pre = wdata[`DTFM_FF_INIT_HI:`DTFM_FF_INIT_LO];

  // gate output: preset by software, otherwise toggled on enabled matches;
  // capture-triggered toggles never fire because the gate channel captures nothing
  always @* begin
    ff_nxt = gate_toggle_output;
    // code 01 presets high, 10 presets low; 00 and 11 preset nothing, so an enabled match in that cycle still toggles
    if (wr_gffcr && (ff_pre == `DTFM_FF_PRE_HI)) begin
      ff_nxt = 1'b1;
    end else if (wr_gffcr && (ff_pre == `DTFM_FF_PRE_LO)) begin
      ff_nxt = 1'b0;
    end else if ((g_m0 & toggle_on_match_zero) ^ (g_m1 & toggle_on_match_one)) begin
      ff_nxt = ~gate_toggle_output;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate_toggle_output <= 1'b0;
      gate_d_r <= 1'b0;
    end else begin
      gate_toggle_output <= ff_nxt;
      gate_d_r <= gate_toggle_output;
    end
  end

  assign gate_rise = gate_toggle_output & ~gate_d_r;
  assign gate_fall = ~gate_toggle_output & gate_d_r;
  assign cap_r_ev = (capture_mode_select == `DTFM_CPM_GATE) & gate_rise;
  assign cap_f_ev = (capture_mode_select == `DTFM_CPM_GATE) & gate_fall;

  // gate up-counter: clears on compare one match (interval timer)
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      g_cnt_r <= 16'h0000;
    end else if (!g_running) begin
      g_cnt_r <= g_cnt_r; // held while stopped
    end else if (g_m1) begin
      g_cnt_r <= 16'h0000;
    end else if (g_tick) begin
      g_cnt_r <= g_cnt_r + 16'h0001;
    end
  end

  // counting channel: free-running 16-bit, wraps; software fixes negative differences
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      c_cnt_r <= 16'h0000;
    end else if (wr && (addr == `DTFM_A_CMOD) && wdata[`DTFM_MOD_CLR]) begin
      c_cnt_r <= 16'h0000;
    end else if (c_adv) begin
      c_cnt_r <= c_cnt_r + 16'h0001;
    end
  end

  // captures hold until the next qualifying gate edge
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      capture_rise_reg_r <= 16'h0000;
      capture_fall_reg_r <= 16'h0000;
    end else begin
      if (cap_r_ev) begin
        capture_rise_reg_r <= c_cnt_r;
      end
      if (cap_f_ev) begin
        capture_fall_reg_r <= c_cnt_r;
      end
    end
  end

  // software registers; compare writes go to buffers when double-buffering is on
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      g_run_r <= 3'h0;
      c_run_r <= 3'h0;
      g_ffcr_r <= `DTFM_FFCR_RST;
      compare_reg_zero_r <= 16'h0000;
      compare_reg_one_r <= 16'h0000;
      g_cmp0_buf_r <= 16'h0000;
      g_cmp1_buf_r <= 16'h0000;
      g_dbuf_r <= 1'b0;
      interrupt_mask_reg_r <= `DTFM_IM_RST;
      counting_mode_reg_r <= `DTFM_MOD_RST;
      psc_div_r <= `DTFM_PSC_RST;
    end else begin
      if (wr) begin
        case (addr)
          `DTFM_A_GRUN: g_run_r <= wdata[2:0];
          `DTFM_A_CRUN: c_run_r <= wdata[2:0];
          `DTFM_A_GFFCR: g_ffcr_r <= {wdata[5:2], 2'b11}; // init bits read back as 11
          `DTFM_A_GCMP0: g_cmp0_buf_r <= wdata;
          `DTFM_A_GCMP1: g_cmp1_buf_r <= wdata;
          `DTFM_A_GIM: interrupt_mask_reg_r <= wdata[4:0];
          `DTFM_A_GCR: g_dbuf_r <= wdata[7];
          `DTFM_A_CMOD: counting_mode_reg_r <= {wdata[5:4], 1'b0, wdata[2:0]};
          `DTFM_A_PSC: psc_div_r <= wdata[7:0];
          default: ;
        endcase
      end
      // unbuffered or stopped: load at once; buffered while running: load at the period end
      if (!g_dbuf_r || !g_running || g_m1) begin
        compare_reg_zero_r <= (wr && addr == `DTFM_A_GCMP0) ? wdata : g_cmp0_buf_r;
        compare_reg_one_r <= (wr && addr == `DTFM_A_GCMP1) ? wdata : g_cmp1_buf_r;
      end
    end
  end

  // sticky status; a set in the reading cycle survives the read-clear
  assign irq_ev = {cap_f_ev, cap_r_ev, g_ovf, g_m1, g_m0};
  assign rd_ist = rd & (addr == `DTFM_A_IST);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= 5'h00;
      gate_match_interrupt <= 1'b0;
    end else begin
      irq_stat_r <= (rd_ist ? 5'h00 : irq_stat_r) | irq_ev;
      // a mask bit of one suppresses its source
      gate_match_interrupt <= |(((rd_ist ? 5'h00 : irq_stat_r) | irq_ev) &
                                ~interrupt_mask_reg_r);
    end
  end

  // read mux; capture registers readable at any time
  always @* begin
    case (addr)
      `DTFM_A_GRUN: rdata_nxt = {13'h0000, g_run_r};
      `DTFM_A_GFFCR: rdata_nxt = {10'h000, g_ffcr_r};
      `DTFM_A_GCMP0: rdata_nxt = compare_reg_zero_r;
      `DTFM_A_GCMP1: rdata_nxt = compare_reg_one_r;
      `DTFM_A_GIM: rdata_nxt = {11'h000, interrupt_mask_reg_r};
      `DTFM_A_GCR: rdata_nxt = {8'h00, g_dbuf_r, 7'h00};
      `DTFM_A_GCNT: rdata_nxt = g_cnt_r;
      `DTFM_A_CRUN: rdata_nxt = {13'h0000, c_run_r};
      `DTFM_A_CMOD: rdata_nxt = {10'h000, counting_mode_reg_r};
      `DTFM_A_CCNT: rdata_nxt = c_cnt_r;
      `DTFM_A_CAPR: rdata_nxt = capture_rise_reg_r;
      `DTFM_A_CAPF: rdata_nxt = capture_fall_reg_r;
      `DTFM_A_IST: rdata_nxt = {11'h000, irq_stat_r};
      `DTFM_A_PSC: rdata_nxt = {8'h00, psc_div_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // read data valid only the cycle after the strobe
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

//--- tb/dtfm_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module dtfm_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic external_count_pin,
  input wire logic gate_toggle_output,
  input wire logic gate_match_interrupt
);
  logic run_r;
  logic ten_r;
  logic [4:0] msk_r;
  wire ffw = wr && addr == 4'h1;
  // shadows of run, match enables and mask; reset like the block
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
      ten_r <= 1'b0;
      msk_r <= 5'h1f;
    end else if (wr) begin
      if (addr == 4'h0) run_r <= wdata[0] & wdata[2];
      if (ffw) ten_r <= |wdata[3:2];
      if (addr == 4'h4) msk_r <= wdata[4:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // two-cycle margin: a match taken just before a stop may still land
  property p_rd_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata outside slot");
  property p_unmap; rd && addr > 4'hd |=> rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_ff_rd; rd && addr == 4'h1 |=> rdata[1:0] == 2'b11; endproperty
  a_ff_rd: assert property (p_ff_rd) else $error("preset field read");
  property p_pre_lo; ffw && wdata[1:0] == 2'b10 |=> !gate_toggle_output; endproperty
  a_pre_lo: assert property (p_pre_lo) else $error("preset low");
  property p_pre_hi; ffw && wdata[1:0] == 2'b01 |=> gate_toggle_output; endproperty
  a_pre_hi: assert property (p_pre_hi) else $error("preset high");
  property p_stop; !wr && !run_r && !$past(run_r, 2) |=> $stable(gate_toggle_output); endproperty
  a_stop: assert property (p_stop) else $error("gate moved while stopped");
  property p_noen; !wr && !ten_r && !$past(ten_r, 2) |=> $stable(gate_toggle_output); endproperty
  a_noen: assert property (p_noen) else $error("gate moved, no enables");
  property p_quiet; msk_r == 5'h1f && $past(msk_r) == 5'h1f |-> !gate_match_interrupt; endproperty
  a_quiet: assert property (p_quiet) else $error("irq while all masked");
  c_rise: cover property ($rose(gate_toggle_output));
  c_fall: cover property ($fell(gate_toggle_output));
  c_irq: cover property ($rose(gate_match_interrupt));
endmodule
bind dtfm_top dtfm_monitor u_mon (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin(external_count_pin),
  .gate_toggle_output(gate_toggle_output), .gate_match_interrupt(gate_match_interrupt));
`default_nettype wire

//--- tb/dtfm_ext_src.sv
`timescale 1ns/10ps
`default_nettype none
module dtfm_ext_src #(parameter int HALF = 5) (
  input wire logic mclk,
  input wire logic en,
  output logic pin = 1'b0
);
  int cnt = 0;
  // free-running measured clock; edges sit on mclk so counts are exact
  always @(posedge mclk) begin
    if (!en) begin
      pin <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      pin <= !pin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic src_en = 1'b0;
  wire [15:0] rdata;
  wire pin;
  wire gate;
  wire irq;
  int miscompares = 0;
  int samples_checked = 0;
  logic [15:0] v;
  logic [15:0] c0;
  logic [15:0] c1;
  always #5 mclk = !mclk;
  dtfm_top i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .external_count_pin(pin), .gate_toggle_output(gate),
    .gate_match_interrupt(irq));
  dtfm_ext_src #(.HALF(5)) i_src (.mclk(mclk), .en(src_en), .pin(pin));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data is only valid in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a full run is about 1300 cycles; over twenty times that means a hang
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rreg(4'h1, v);
    check("ffcr", v, 16'h0003);
    rreg(4'h4, v);
    check("mask", v, 16'h001f);
    rreg(4'ha, v);
    check("capture rise", v, 16'h0000);
    rreg(4'he, v);
    check("unmapped", v, 16'h0000);
    $display("reset test done");
    // stop both channels before configuring the measurement
    wreg(4'h0, 16'h0000);
    wreg(4'h7, 16'h0000);
    wreg(4'h5, 16'h0080);
    wreg(4'h2, 16'd100);
    wreg(4'h3, 16'd500);
    wreg(4'h1, 16'h000e);
    wreg(4'h8, 16'h0038);
    wreg(4'h4, 16'h001d);
    wreg(4'hd, 16'h0000);
    src_en <= 1'b1;
    wreg(4'h7, 16'h0005);
    wreg(4'h0, 16'h0005);
    for (int i = 0; i < 2000 && gate !== 1'b1; i++) @(negedge mclk);
    check("gate rise", {15'h0, gate}, 16'h0001);
    check("irq on cmp0", {15'h0, irq}, 16'h0000);
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(negedge mclk);
    check("gate fall", {15'h0, gate}, 16'h0000);
    // handler: halt toggling, then clear status and read captures
    wreg(4'h1, 16'h0000);
    rreg(4'hc, v);
    check("status", v, 16'h001b);
    repeat (2) @(negedge mclk);
    check("irq cleared", {15'h0, irq}, 16'h0000);
    rreg(4'ha, c0);
    rreg(4'hb, c1);
    check("edge count", c1 - c0, 16'd40);
    $display("frequency test done");
    // later matches must neither toggle nor capture
    repeat (700) @(negedge mclk);
    check("gate held", {15'h0, gate}, 16'h0000);
    rreg(4'ha, v);
    check("rise held", v, c0);
    rreg(4'hb, v);
    check("fall held", v, c1);
    // dropping one run bit stops the counter while pin edges go on
    wreg(4'h7, 16'h0004);
    rreg(4'h9, c0);
    repeat (50) @(negedge mclk);
    rreg(4'h9, v);
    check("stopped count", v, c0);
    wreg(4'h1, 16'h0001);
    @(negedge mclk);
    check("preset high", {15'h0, gate}, 16'h0001);
    wreg(4'h1, 16'h0002);
    @(negedge mclk);
    check("preset low", {15'h0, gate}, 16'h0000);
    $display("hold and preset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
